// file: inc/cpu_bus_pkg.sv
package cpu_bus_pkg;

  // bus clock
  localparam int CLK_PERIOD_NS = 40;

  // bus status codes
  localparam logic [4:0] STATUS_IDLE = 5'h00;
  localparam logic [4:0] STATUS_SEQ_FETCH = 5'h08;
  localparam logic [4:0] STATUS_NONSEQ_FETCH = 5'h09;
  localparam logic [4:0] STATUS_DATA_XFER = 5'h0A;
  localparam logic [4:0] STATUS_RMW_READ = 5'h0B;
  localparam logic [4:0] STATUS_EA_READ = 5'h0C;

  // width code for 32-bit memory, block and burst limits
  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [1:0] DWORD_LAST = 2'h3;
  localparam logic [1:0] NIBBLE_MAX = 2'h3;
  localparam logic [1:0] COUNT_RST = 2'h0;
  localparam logic [1:0] COUNT_FIRST = 2'h1;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [3:0] BE_NONE = 4'h0;

  // reset values and pin input width
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] WIDTH_RST = 2'h0;
  localparam int PIN_W = 40;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    BUS_IDLE = 6'h01,
    LOCK_LEAD = 6'h02,
    FIRST_TRANSFER_STATE = 6'h04,
    SECOND_TRANSFER_STATE = 6'h08,
    BURST_NIBBLE_STATE = 6'h10,
    LOCK_TRAIL = 6'h20
  } bus_state_t;

  // request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] status;
    logic write;
    logic locked;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bus_req_t;

  // answer to the core, one per data item
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] rdata;
    logic err;
    logic retry;
    logic inhibit;
    logic last;
  } bus_rsp_t;

  // bus inputs from pins
  typedef struct packed {
    logic ready_n;
    logic burst_accept_in_n;
    logic bus_error_in_n;
    logic bus_retry_in_n;
    logic [1:0] bus_width_in;
    logic io_decode_in_n;
    logic cache_inhibit_in;
    logic [31:0] data;
  } pin_in_t;

  localparam pin_in_t PIN_IN_RST = '{1'b1, 1'b1, 1'b1, 1'b1, WIDTH_RST, 1'b1, 1'b0, DATA_RST};

endpackage : cpu_bus_pkg

// file: design/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins and their synchronised copy
  input wire cpu_bus_pkg::pin_in_t raw,
  output cpu_bus_pkg::pin_in_t synced
);

  logic [cpu_bus_pkg::PIN_W-1:0] meta_q;
  logic [cpu_bus_pkg::PIN_W-1:0] sync_q;

  // two flops per pin bit; first stage feeds only the second
  for (genvar i = 0; i < cpu_bus_pkg::PIN_W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        meta_q[i] <= cpu_bus_pkg::PIN_IN_RST[i];
        sync_q[i] <= cpu_bus_pkg::PIN_IN_RST[i];
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign synced = sync_q;

endmodule : pin_sync

// file: design/burst_stepper.sv
`timescale 1ns/100ps
module burst_stepper (
  // current nibble address and count
  input wire logic [31:0] addr,
  input wire logic [1:0] count,
  // next nibble address and end conditions
  output logic [31:0] next_addr,
  output logic [1:0] next_count,
  output logic block_last,
  output logic count_done
);

  // wrap dword index inside the 16-byte block, zero byte offset
  always_comb begin
    next_addr = {addr[31:4], 2'(addr[3:2] + 2'h1), 2'h0};
    next_count = 2'(count + 2'h1);
    block_last = (addr[3:2] == cpu_bus_pkg::DWORD_LAST);
    count_done = (count == cpu_bus_pkg::NIBBLE_MAX);
  end

endmodule : burst_stepper

// file: design/cpu_bus_sequencer.sv
`timescale 1ns/100ps
module cpu_bus_sequencer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request port from the core
  input wire logic req_valid,
  input wire cpu_bus_pkg::bus_req_t req,
  output logic req_ready,
  input wire logic flow_change,
  input wire logic data_cache_enable_bit,
  input wire logic data_cache_lock_bit,
  input wire logic interlocked_bit_instr,
  // answer port to the core
  output logic rsp_valid,
  output cpu_bus_pkg::bus_rsp_t rsp,
  // bus pins in
  input wire cpu_bus_pkg::pin_in_t pin_in,
  // bus pins out
  output logic [31:0] addr_out,
  output logic [4:0] status_out,
  output logic cycle_start_n,
  output logic [3:0] byte_enable_lines_n,
  output logic write_out,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic burst_request_out_n,
  output logic interlock_out_n
);

  cpu_bus_pkg::bus_state_t state_q, state_d;
  cpu_bus_pkg::bus_req_t cur_q, cur_d;
  cpu_bus_pkg::bus_rsp_t rsp_q, rsp_d;
  cpu_bus_pkg::pin_in_t pins;
  logic [31:0] addr_q, addr_d;
  logic [3:0] be_q, be_d;
  logic [1:0] count_q, count_d;
  logic burst_q, burst_d;
  logic fetch_q, fetch_d;
  logic lock_q, lock_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [31:0] step_addr;
  logic [1:0] step_count;
  logic block_last;
  logic count_done;
  logic rdy_act;
  logic req_fetch;
  logic req_data_rd;
  logic burst_ok;
  logic cont_open;
  logic nib_stop;
  logic cycle_end_lock;
  logic busy;

  // all bus inputs pass two flops first
  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw(pin_in),
    .synced(pins)
  );

  // nibble address stepping and burst length
  burst_stepper u_burst_stepper (
    .addr(addr_q),
    .count(count_q),
    .next_addr(step_addr),
    .next_count(step_count),
    .block_last(block_last),
    .count_done(count_done)
  );

  // burst eligibility of the incoming request
  always_comb begin
    rdy_act = !pins.ready_n;
    req_fetch = (req.status == cpu_bus_pkg::STATUS_SEQ_FETCH) ||
                (req.status == cpu_bus_pkg::STATUS_NONSEQ_FETCH);
    req_data_rd = (req.status == cpu_bus_pkg::STATUS_DATA_XFER) ||
                  (req.status == cpu_bus_pkg::STATUS_RMW_READ) ||
                  (req.status == cpu_bus_pkg::STATUS_EA_READ);
    burst_ok = !req.write &&
               ((req_fetch && (req.addr[3:2] != cpu_bus_pkg::DWORD_LAST)) ||
                (req_data_rd && data_cache_enable_bit && !data_cache_lock_bit &&
                 !(req.locked && interlocked_bit_instr)));
  end

  // burst continuation and termination, using final wait state inputs only
  always_comb begin
    cont_open = burst_q && !pins.burst_accept_in_n &&
                pins.bus_retry_in_n &&
                pins.io_decode_in_n && (pins.bus_width_in == cpu_bus_pkg::WIDTH_32) &&
                !(fetch_q && flow_change);
    nib_stop = pins.burst_accept_in_n || !pins.bus_retry_in_n ||
               (fetch_q ? (block_last || flow_change) : count_done);
    cycle_end_lock = cur_q.locked &&
                     (cur_q.write ? pins.bus_retry_in_n : !pins.bus_error_in_n);
  end

  // only idle may take a request; while locked only locked accesses pass
  assign req_ready = (state_q == cpu_bus_pkg::BUS_IDLE) && (!lock_q || req.locked);

  // sequencer next state and datapath
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    addr_d = addr_q;
    be_d = be_q;
    count_d = count_q;
    burst_d = burst_q;
    fetch_d = fetch_q;
    lock_d = lock_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    case (state_q)
      cpu_bus_pkg::BUS_IDLE: begin
        if (req_valid && req_ready) begin
          cur_d = req;
          addr_d = req.addr;
          be_d = req.byte_en;
          burst_d = burst_ok;
          fetch_d = req_fetch;
          count_d = cpu_bus_pkg::COUNT_RST;
          if (req.locked && !lock_q) begin
            lock_d = 1'b1;
            state_d = cpu_bus_pkg::LOCK_LEAD;
          end else begin
            state_d = cpu_bus_pkg::FIRST_TRANSFER_STATE;
          end
        end
      end
      cpu_bus_pkg::LOCK_LEAD: begin
        state_d = cpu_bus_pkg::FIRST_TRANSFER_STATE;
      end
      cpu_bus_pkg::FIRST_TRANSFER_STATE: begin
        state_d = cpu_bus_pkg::SECOND_TRANSFER_STATE;
      end
      cpu_bus_pkg::SECOND_TRANSFER_STATE: begin
        if (rdy_act) begin
          rsp_valid_d = 1'b1;
          rsp_d.addr = addr_q;
          rsp_d.rdata = pins.data;
          rsp_d.err = !pins.bus_error_in_n;
          rsp_d.retry = !pins.bus_retry_in_n;
          rsp_d.inhibit = pins.cache_inhibit_in;
          rsp_d.last = !cont_open;
          if (cont_open) begin
            state_d = cpu_bus_pkg::BURST_NIBBLE_STATE;
            addr_d = step_addr;
            be_d = cpu_bus_pkg::BE_ALL;
            count_d = cpu_bus_pkg::COUNT_FIRST;
          end else begin
            burst_d = 1'b0;
            state_d = cycle_end_lock ? cpu_bus_pkg::LOCK_TRAIL : cpu_bus_pkg::BUS_IDLE;
          end
        end
      end
      cpu_bus_pkg::BURST_NIBBLE_STATE: begin
        if (rdy_act) begin
          rsp_valid_d = 1'b1;
          rsp_d.addr = addr_q;
          rsp_d.rdata = pins.data;
          rsp_d.err = !pins.bus_error_in_n;
          rsp_d.retry = !pins.bus_retry_in_n;
          rsp_d.inhibit = pins.cache_inhibit_in;
          rsp_d.last = nib_stop;
          if (nib_stop) begin
            burst_d = 1'b0;
            state_d = cpu_bus_pkg::BUS_IDLE;
          end else begin
            addr_d = step_addr;
            count_d = step_count;
          end
        end
      end
      cpu_bus_pkg::LOCK_TRAIL: begin
        lock_d = 1'b0;
        state_d = cpu_bus_pkg::BUS_IDLE;
      end
      default: begin
        state_d = cpu_bus_pkg::BUS_IDLE;
      end
    endcase
  end

  // sequencer registers; reset drops any cycle regardless of ready
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= cpu_bus_pkg::BUS_IDLE;
      cur_q <= '0;
      addr_q <= cpu_bus_pkg::ADDR_RST;
      be_q <= cpu_bus_pkg::BE_NONE;
      count_q <= cpu_bus_pkg::COUNT_RST;
      burst_q <= 1'b0;
      fetch_q <= 1'b0;
      lock_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      addr_q <= addr_d;
      be_q <= be_d;
      count_q <= count_d;
      burst_q <= burst_d;
      fetch_q <= fetch_d;
      lock_q <= lock_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

  // bus pin drive
  always_comb begin
    busy = (state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE) ||
           (state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) ||
           (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE);
    addr_out = addr_q;
    status_out = busy ? cur_q.status : cpu_bus_pkg::STATUS_IDLE;
    cycle_start_n = !(state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE);
    byte_enable_lines_n = busy ? ~be_q : ~cpu_bus_pkg::BE_NONE;
    write_out = busy && cur_q.write;
    data_out = cur_q.wdata;
    data_oe = cur_q.write && ((state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE) ||
                              (state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE));
    // request drops in the same cycle that a refused burst ends
    burst_request_out_n = !(burst_q && busy &&
                            !((state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act && !cont_open));
    interlock_out_n = !lock_q;
    rsp_valid = rsp_valid_q;
    rsp = rsp_q;
  end

  // checks on the sequencer
  default clocking main_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_open_refused;
    (state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act && !cont_open;
  endsequence

  sequence seq_last_data_nibble;
    (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && rdy_act && !fetch_q && (count_q == 2'h3);
  endsequence

  sequence seq_locked_read_error;
    (state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act && cur_q.locked &&
    !cur_q.write && !pins.bus_error_in_n;
  endsequence

  sequence seq_lock_lead;
    (state_q == cpu_bus_pkg::LOCK_LEAD) ##1 (state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE);
  endsequence

  AST_NO_BURST_WRITE: assert property (
    (write_out && busy) |-> burst_request_out_n)
    else $error("burst request asserted on a write cycle");

  AST_OPENING_OFFERS_BURST: assert property (
    ((state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE) && burst_q) |->
      !burst_request_out_n && !cycle_start_n && (status_out == cur_q.status))
    else $error("opening cycle does not offer burst");

  AST_REFUSED_BURST_ENDS: assert property (
    seq_open_refused |-> burst_request_out_n ##1
      (state_q != cpu_bus_pkg::BURST_NIBBLE_STATE) && burst_request_out_n)
    else $error("refused burst did not end");

  AST_DATA_BURST_FOUR: assert property (
    seq_last_data_nibble |=> (state_q == cpu_bus_pkg::BUS_IDLE) && burst_request_out_n)
    else $error("data burst ran past four dwords");

  AST_NIBBLE_ADDRESS: assert property (
    (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) |->
      (addr_out[1:0] == 2'h0) && (byte_enable_lines_n == 4'h0) && (count_q != 2'h0))
    else $error("nibble address or byte enables wrong");

  AST_NIBBLE_STEP: assert property (
    ((state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && rdy_act && !nib_stop) |=>
      (addr_out[3:2] == 2'($past(addr_out[3:2]) + 2'h1)) && (addr_out[31:4] == $past(addr_out[31:4])))
    else $error("nibble address did not step");

  AST_WAIT_HOLDS: assert property (
    ((state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && !rdy_act) |=>
      (state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && $stable(addr_out) && !rsp_valid)
    else $error("wait state not held");

  AST_BUS_ERROR_KEEPS_BURST: assert property (
    ((state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && rdy_act && !pins.bus_error_in_n &&
     !pins.burst_accept_in_n && pins.bus_retry_in_n && !fetch_q && (count_q == 2'h1)) |=>
      (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE))
    else $error("bus error stopped a burst");

  AST_LOCK_LEADS_READ: assert property (
    $fell(interlock_out_n) |-> seq_lock_lead)
    else $error("interlock not set in idle before first transfer");

  AST_LOCK_EXCLUSIVE: assert property (
    (!interlock_out_n && (state_q == cpu_bus_pkg::FIRST_TRANSFER_STATE)) |-> cur_q.locked)
    else $error("foreign bus cycle inside interlocked transaction");

  AST_LOCK_GAP: assert property (
    $rose(interlock_out_n) |-> (state_q == cpu_bus_pkg::BUS_IDLE) && cycle_start_n)
    else $error("interlock not released for a full idle cycle");

  AST_LOCK_ERROR_RELEASE: assert property (
    seq_locked_read_error |=> (state_q == cpu_bus_pkg::LOCK_TRAIL) ##1
      interlock_out_n && (state_q == cpu_bus_pkg::BUS_IDLE))
    else $error("interlock kept after error on interlocked read");

  AST_RESET_ABORTS: assert property (disable iff (1'b0)
    !rst_n |=> (state_q == cpu_bus_pkg::BUS_IDLE) && cycle_start_n && interlock_out_n)
    else $error("reset did not abort the bus cycle");

  AST_ACCEPT_CONTINUES: assert property (
    ((state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act && cont_open) |=>
      (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && !burst_request_out_n)
    else $error("accepted burst did not continue");

  sequence seq_nibble_stall;
    (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && !rdy_act;
  endsequence

  AST_NIBBLE_WAIT: assert property (
    seq_nibble_stall |=> (state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && $stable(addr_out) && !rsp_valid)
    else $error("nibble not stretched while ready inactive");

  AST_FETCH_BLOCK_END: assert property (
    ((state_q == cpu_bus_pkg::BURST_NIBBLE_STATE) && rdy_act && fetch_q && (addr_out[3:2] == 2'h3)) |=>
      (state_q == cpu_bus_pkg::BUS_IDLE) && burst_request_out_n)
    else $error("fetch burst ran past the end of its block");

  AST_RETRY_ENDS_BURST: assert property (
    ((state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act && !pins.bus_retry_in_n) |->
      burst_request_out_n ##1 (state_q != cpu_bus_pkg::BURST_NIBBLE_STATE))
    else $error("bus retry did not end the burst");

  AST_WIDTH_ENDS_BURST: assert property (
    ((state_q == cpu_bus_pkg::SECOND_TRANSFER_STATE) && rdy_act &&
     (pins.bus_width_in != cpu_bus_pkg::WIDTH_32)) |-> burst_request_out_n ##1
      (state_q != cpu_bus_pkg::BURST_NIBBLE_STATE))
    else $error("narrow bus width did not end the burst");

  AST_LOCK_TRAIL_RELEASE: assert property (
    (state_q == cpu_bus_pkg::LOCK_TRAIL) |-> !interlock_out_n ##1 interlock_out_n)
    else $error("interlock not released after the interlocked pair");

endmodule : cpu_bus_sequencer

// file: bench/mem_partner.sv
`timescale 1ns/100ps
// memory on the far side of the bus; answers after a set number of wait states
module mem_partner (
  // clock and sequencer outputs
  input wire logic sys_clk,
  input wire logic [31:0] addr_out,
  input wire logic [4:0] status_out,
  // behaviour knobs from the bench
  input wire logic [3:0] waits,
  input wire logic accept,
  input wire logic [1:0] width,
  input wire logic io_sel,
  input wire logic retry,
  input wire logic err,
  // pins back to the sequencer
  output cpu_bus_pkg::pin_in_t pin_in
);
  int cnt = 0;
  logic fin = 1'b0;

  // pins start quiet, then change only off the falling edge; control pins only count in the final wait state
  initial begin
    pin_in = cpu_bus_pkg::PIN_IN_RST;
    forever begin
      @(negedge sys_clk);
      if (status_out == cpu_bus_pkg::STATUS_IDLE) begin
        cnt = 0;
        fin = 1'b0;
        pin_in.data = ~pin_in.data; // released bus shows no stale value
        pin_in.bus_width_in = cpu_bus_pkg::WIDTH_RST;
      end else begin
        fin = (cnt == int'(waits));
        cnt = fin ? -4 : cnt + 1; // gap covers the two-flop input lag
        pin_in.data = {addr_out[31:2], 2'b00} ^ 32'hA5A5_0000;
        pin_in.bus_width_in = width;
      end
      pin_in.ready_n = ~fin;
      pin_in.burst_accept_in_n = ~(fin & accept);
      pin_in.bus_retry_in_n = ~(fin & retry);
      pin_in.bus_error_in_n = ~(fin & err);
      pin_in.io_decode_in_n = ~(fin & io_sel);
      pin_in.cache_inhibit_in = fin & err;
    end
  end
endmodule : mem_partner

// file: bench/cpu_burst_wait_interlock_bus_tb.sv
`timescale 1ns/100ps
module cpu_burst_wait_interlock_bus_tb;
  // row: address, status, flags, waits, width, items
  // flags: 0 write, 1 cache on, 2 cache locked, 3 accept, 4 io, 5 retry, 6 error, 7 flow change
  typedef struct packed {
    logic [31:0] a;
    logic [4:0] st;
    logic [7:0] f;
    logic [3:0] w;
    logic [1:0] wid;
    logic [2:0] n;
  } row_t;
  localparam row_t ROWS [16] = '{
    '{32'h0000_0104, 5'h08, 8'h08, 4'h0, 2'h3, 3'h3}, '{32'h0000_010C, 5'h09, 8'h08, 4'h0, 2'h3, 3'h1},
    '{32'h0000_0104, 5'h0A, 8'h0A, 4'h0, 2'h3, 3'h4}, '{32'h0000_0200, 5'h0B, 8'h0A, 4'h2, 2'h3, 3'h4},
    '{32'h0000_0208, 5'h0C, 8'h0A, 4'h0, 2'h3, 3'h4}, '{32'h0000_0300, 5'h0A, 8'h0B, 4'h0, 2'h3, 3'h1},
    '{32'h0000_0304, 5'h0A, 8'h08, 4'h0, 2'h3, 3'h1}, '{32'h0000_0308, 5'h0A, 8'h0E, 4'h0, 2'h3, 3'h1},
    '{32'h0000_0310, 5'h1D, 8'h0A, 4'h0, 2'h3, 3'h1}, '{32'h0000_0314, 5'h0A, 8'h02, 4'h0, 2'h3, 3'h1},
    '{32'h0000_0318, 5'h0A, 8'h0A, 4'h0, 2'h1, 3'h1}, '{32'h0000_0320, 5'h0A, 8'h1A, 4'h0, 2'h3, 3'h1},
    '{32'h0000_0324, 5'h0A, 8'h2A, 4'h0, 2'h3, 3'h1}, '{32'h0000_0104, 5'h0A, 8'h4A, 4'h0, 2'h3, 3'h4},
    '{32'h0000_0100, 5'h08, 8'h88, 4'h0, 2'h3, 3'h2}, '{32'h0000_010C, 5'h0A, 8'h0A, 4'h3, 2'h3, 3'h4}};
  localparam row_t LK_RD = '{32'h0000_0400, 5'h0B, 8'h0A, 4'h0, 2'h3, 3'h1};
  localparam row_t LK_WR = '{32'h0000_0400, 5'h0A, 8'h0B, 4'h0, 2'h3, 3'h1};
  localparam row_t LK_ER = '{32'h0000_0400, 5'h0B, 8'h4A, 4'h0, 2'h3, 3'h1};

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  cpu_bus_pkg::bus_req_t req = '0;
  logic req_ready, flow_change = 1'b0, ce = 1'b0, cl = 1'b0, bit_instr = 1'b0, lk = 1'b0;
  logic rsp_valid, cycle_start_n, write_out, data_oe, burst_request_out_n, interlock_out_n;
  cpu_bus_pkg::bus_rsp_t rsp;
  cpu_bus_pkg::pin_in_t pin_in;
  logic [31:0] addr_out, data_out;
  logic [4:0] status_out;
  logic [3:0] byte_enable_lines_n, w = 4'h0;
  logic [1:0] wid = 2'h3;
  logic acc = 1'b0, io = 1'b0, rt = 1'b0, er = 1'b0;
  int miscompares = 0;
  int checked = 0;

  // bus clock
  always #20 sys_clk = ~sys_clk;

  cpu_bus_sequencer i_cpu_bus_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .flow_change(flow_change), .data_cache_enable_bit(ce), .data_cache_lock_bit(cl),
    .interlocked_bit_instr(bit_instr), .rsp_valid(rsp_valid), .rsp(rsp), .pin_in(pin_in), .addr_out(addr_out),
    .status_out(status_out), .cycle_start_n(cycle_start_n), .byte_enable_lines_n(byte_enable_lines_n),
    .write_out(write_out), .data_out(data_out), .data_oe(data_oe), .burst_request_out_n(burst_request_out_n),
    .interlock_out_n(interlock_out_n));

  mem_partner i_mem_partner (.sys_clk(sys_clk), .addr_out(addr_out), .status_out(status_out), .waits(w),
    .accept(acc), .width(wid), .io_sel(io), .retry(rt), .err(er), .pin_in(pin_in));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic elig(input row_t r);
    if (r.st == 5'h08 || r.st == 5'h09) return r.a[3:2] != 2'h3;
    return r.st >= 5'h0A && r.st <= 5'h0C && r.f[1] && !r.f[2] && !r.f[0] && !(lk && bit_instr);
  endfunction : elig

  // present one request and hold it until taken
  task automatic issue(input row_t r);
    int k;
    req = '{r.a, r.st, r.f[0], lk, 4'hF, 32'h1234_5678};
    {w, wid, acc, io, rt, er, ce, cl} = {r.w, r.wid, r.f[3], r.f[4], r.f[5], r.f[6], r.f[1], r.f[2]};
    @(negedge sys_clk);
    req_valid = 1'b1;
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask : issue

  // issue, then collect every item and watch the pins meanwhile
  task automatic run(input row_t r);
    int got;
    int k;
    logic [31:0] ea;
    got = 0;
    issue(r);
    for (k = 0; k < 400 && got < r.n; k++) begin
      if (cycle_start_n === 1'b0) begin
        chk(burst_request_out_n, !elig(r));
        chk(status_out, r.st);
        chk(addr_out, r.a);
        chk(write_out, r.f[0]);
        if (r.f[0]) chk({data_oe, data_out}, {1'b1, 32'h1234_5678});
      end
      if (got > 0 && status_out !== 5'h00) begin
        chk(byte_enable_lines_n, cpu_bus_pkg::BE_NONE);
        chk(addr_out[1:0], 2'h0);
      end
      if (rsp_valid === 1'b1) begin
        ea = {r.a[31:4], r.a[3:2] + got[1:0], 2'b00};
        chk(rsp.addr, ea);
        chk(rsp.last, got == r.n - 1);
        chk(rsp.err, r.f[6]);
        chk(rsp.inhibit, r.f[6]);
        chk(rsp.retry, r.f[5]);
        if (r.f[6:5] == 2'h0 && !r.f[0]) chk(rsp.rdata, ea ^ 32'hA5A5_0000);
        got++;
        flow_change = r.f[7];
      end
      if (got < r.n) @(negedge sys_clk);
    end
    repeat (8) begin
      @(negedge sys_clk);
      if (rsp_valid === 1'b1) got++;
    end
    chk(got, r.n);
    flow_change = 1'b0;
  endtask : run

  // wait a few cycles for the interlock to drop
  task automatic lock_gone();
    int k;
    for (k = 0; k < 4 && interlock_out_n !== 1'b1; k++) @(negedge sys_clk);
    chk(interlock_out_n, 1'b1);
  endtask : lock_gone

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    #(40 * 20000);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (ROWS[i]) begin
      run(ROWS[i]);
      $display("row %0d done", i);
    end
    lk = 1'b1;
    bit_instr = 1'b1;
    run(LK_RD);
    chk(interlock_out_n, 1'b0);
    req.locked = 1'b0;
    #1;
    chk(req_ready, 1'b0);
    run(LK_WR);
    lock_gone();
    run(LK_ER);
    lock_gone();
    lk = 1'b0;
    bit_instr = 1'b0;
    $display("interlock test done");
    issue('{32'h0000_0500, 5'h0A, 8'h0A, 4'hF, 2'h3, 3'h4});
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    chk({cycle_start_n, burst_request_out_n, byte_enable_lines_n, status_out}, 11'h7E0);
    chk({data_oe, interlock_out_n, rsp_valid}, 3'h2);
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    w = 4'h0;
    run(ROWS[2]);
    $display("reset test done");
    wrap_up();
  end
endmodule : cpu_burst_wait_interlock_bus_tb
